/* rtl/aavs_accum.sv */
// Purpose: Sample accumulator and averaging shifter.
// Assumes: Up to 128 samples of SAMPLE_W bits per run.
// Notes: Clear has priority over add; average is a combinational view of the sum.
`timescale 1ns/1ps
module aavs_accum
	import aavs_pkg::*;
#(
	parameter int DATA_W = SAMPLE_W,
	parameter int SUM_W = ACC_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic add,
	input wire logic signed_mode,
	input wire logic [SHIFT_W-1:0] shift,
	input wire logic [DATA_W-1:0] sample,
	output logic [DATA_W-1:0] avg
);

	logic [SUM_W-1:0] acc_ff;
	logic [SUM_W-1:0] ext_sample;
	logic [SUM_W-1:0] shifted;

	always_comb begin
		if (signed_mode) begin
			ext_sample = {{(SUM_W-DATA_W){sample[DATA_W-1]}}, sample};
			shifted = SUM_W'($signed(acc_ff) >>> shift);
		end else begin
			// Logical shift keeps the top bits clear for large unsigned sums
			ext_sample = {{(SUM_W-DATA_W){1'b0}}, sample};
			shifted = acc_ff >> shift; // RQ4
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_ff <= '0;
		end else if (clr) begin
			acc_ff <= '0;
		end else if (add) begin
			acc_ff <= SUM_W'(acc_ff + ext_sample);
		end
	end

	assign avg = shifted[DATA_W-1:0];

endmodule

/* rtl/aavs_pkg.sv */
// Purpose: Shared constants and types of the converter averaging sequencer.
// Assumes: 32-bit AHB-Lite register bus, 12-bit raw samples from the converter core.
// Notes: Register map, field positions, reset values and sequencer states.
// Notes on behaviour
// RQ1 - With scanning, finish all N samples on a channel before advancing the scan offset.
// RQ2 - One software start runs all N conversions and the average, no more triggers.
// RQ3 - Optional interrupt raised only after the Nth conversion and its average complete.
// RQ4 - Unsigned averaging shifts in zeros at the top, never a copied sign bit.
// RQ5 - One event starts and completes the whole N-sample averaging run.
// RQ6 - Clearing free-running stops the ongoing run at once; partial sums may remain.
// RQ7 - After free-running, software disables then re-enables before the next conversion.
// RQ8 - Unsigned mode with offset correction saturates a negative result at zero.
// RQ9 - Disabling the converter clears the accumulator and the sample counter.
package aavs_pkg;

	localparam int SAMPLE_W = 12;
	localparam int CHAN_W = 4;
	localparam int SHIFT_W = 3;
	localparam int CNT_W = 8;
	localparam int ACC_W = SAMPLE_W + 7;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CFG = 8'h04;
	localparam logic [7:0] OFF_OFFS = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] OFF_RES = 8'h10;

	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	localparam int CTRL_FREE_BIT = 2;
	localparam int CTRL_EVT_BIT = 3;
	localparam int CTRL_SCAN_BIT = 4;
	localparam int CTRL_SIGNED_BIT = 5;
	localparam int CTRL_OFFCOR_BIT = 6;
	localparam int CTRL_IRQEN_BIT = 7;
	localparam int CTRL_W = 8;

	localparam int CFG_SHIFT_LSB = 0;
	localparam int CFG_BASE_LSB = 8;
	localparam int CFG_SCAN_LSB = 12;
	localparam int CFG_W = 16;

	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_CHAN_LSB = 8;
	localparam int STAT_CNT_LSB = 16;

	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
	localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
	localparam logic [SAMPLE_W-1:0] OFFS_RST = 12'h000;
	localparam logic [SAMPLE_W-1:0] RES_RST = 12'h000;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_AVG} aavs_state_e;

endpackage

/* rtl/aavs_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for the event trigger.
// Assumes: Input may come from any clock domain.
// Notes: Output level changes only when stages two and three agree.
`timescale 1ns/1ps
module aavs_sync
	import aavs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic async_in,
	output logic level_out,
	output logic rise_out
);

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			level_ff <= 1'b0;
		end else if (s2_ff == s3_ff) begin
			level_ff <= s3_ff;
		end
	end

	assign level_out = level_ff;
	assign rise_out = (s2_ff == s3_ff) && s3_ff && !level_ff;

endmodule

/* rtl/aavs_top.sv */
// Purpose: Averaging and correction sequencer in front of the converter core.
// Assumes: Core takes a one-cycle start and answers with a one-cycle done plus data.
// Notes: Registers on AHB-Lite, zero wait states, always OKAY.
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module aavs_top
	import aavs_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic EVT_TRIG,
	output logic CONV_START,
	output logic [CHAN_W-1:0] CONV_CHAN,
	input wire logic CONV_DONE,
	input wire logic [SAMPLE_W-1:0] CONV_DATA,
	output logic AVG_DONE_IRQ
);

	function automatic logic [SAMPLE_W-1:0] correct(
		input logic [SAMPLE_W-1:0] val,
		input logic [SAMPLE_W-1:0] offs,
		input logic cor_en,
		input logic signed_mode
	);
		logic [SAMPLE_W-1:0] res;
		res = val;
		if (cor_en) begin
			if (!signed_mode && (val < offs)) begin
				res = '0; // RQ8
			end else begin
				res = SAMPLE_W'(val - offs);
			end
		end
		return res;
	endfunction

	logic ph_valid_ff;
	logic ph_write_ff;
	logic [7:0] ph_addr_ff;
	logic [31:0] hrdata_ff;
	logic [CTRL_W-1:0] ctrl_ff;
	logic [CFG_W-1:0] cfg_ff;
	logic [SAMPLE_W-1:0] offs_ff;
	logic [SAMPLE_W-1:0] result_ff;
	logic done_ff;
	logic free_prev_ff;
	aavs_state_e state_ff;
	logic [CNT_W-1:0] samp_cnt_ff;
	logic [CHAN_W-1:0] scan_idx_ff;
	logic [CHAN_W-1:0] nxt_scan_idx;
	logic [CHAN_W-1:0] chan_ff;

	logic addr_take;
	logic wr_en;
	logic sw_start;
	logic done_clr;
	logic en;
	logic free_run;
	logic evt_rise;
	logic trigger;
	logic free_abort;
	logic sample_in;
	logic last_sample;
	logic more_chan;
	logic acc_clr;
	logic [SHIFT_W-1:0] shift;
	logic [CHAN_W-1:0] chan_base;
	logic [CHAN_W-1:0] scan_last;
	logic [CNT_W-1:0] n_last;
	logic [SAMPLE_W-1:0] avg;
	logic [31:0] rd_mux;

	// Bus slave
	assign addr_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
	assign wr_en = ph_valid_ff && ph_write_ff;
	assign HREADYOUT = 1'b1;
	assign HRESP = HRESP_OKAY;
	assign HRDATA = hrdata_ff;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ph_valid_ff <= 1'b0;
			ph_write_ff <= 1'b0;
			ph_addr_ff <= 8'h00;
		end else if (HREADY) begin
			ph_valid_ff <= addr_take;
			ph_write_ff <= HWRITE;
			ph_addr_ff <= HADDR[7:0];
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (HADDR[7:0] == OFF_CTRL) begin
			rd_mux[CTRL_W-1:0] = ctrl_ff;
		end else if (HADDR[7:0] == OFF_CFG) begin
			rd_mux[CFG_W-1:0] = cfg_ff;
		end else if (HADDR[7:0] == OFF_OFFS) begin
			rd_mux[SAMPLE_W-1:0] = offs_ff;
		end else if (HADDR[7:0] == OFF_STAT) begin
			rd_mux[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
			rd_mux[STAT_DONE_BIT] = done_ff;
			rd_mux[STAT_CHAN_LSB +: CHAN_W] = chan_ff;
			rd_mux[STAT_CNT_LSB +: CNT_W] = samp_cnt_ff;
		end else if (HADDR[7:0] == OFF_RES) begin
			rd_mux[SAMPLE_W-1:0] = result_ff;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (addr_take && !HWRITE) begin
			hrdata_ff <= rd_mux;
		end
	end

	// Control registers; the start bit is a strobe and is never stored
	assign sw_start = wr_en && (ph_addr_ff == OFF_CTRL) && HWDATA[CTRL_START_BIT];
	assign done_clr = wr_en && (ph_addr_ff == OFF_STAT) && HWDATA[STAT_DONE_BIT];

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr_en && (ph_addr_ff == OFF_CTRL)) begin
			ctrl_ff <= HWDATA[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_START_BIT);
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg_ff <= CFG_RST;
		end else if (wr_en && (ph_addr_ff == OFF_CFG)) begin
			cfg_ff <= HWDATA[CFG_W-1:0];
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			offs_ff <= OFFS_RST;
		end else if (wr_en && (ph_addr_ff == OFF_OFFS)) begin
			offs_ff <= HWDATA[SAMPLE_W-1:0];
		end
	end

	assign en = ctrl_ff[CTRL_EN_BIT];
	assign free_run = ctrl_ff[CTRL_FREE_BIT];
	assign shift = cfg_ff[CFG_SHIFT_LSB +: SHIFT_W];
	assign chan_base = cfg_ff[CFG_BASE_LSB +: CHAN_W];
	assign scan_last = ctrl_ff[CTRL_SCAN_BIT] ? cfg_ff[CFG_SCAN_LSB +: CHAN_W] : '0;
	assign n_last = CNT_W'((CNT_W'(1) << shift) - CNT_W'(1));

	aavs_sync u_evt_sync (
		.clk(CLK),
		.rst_b(RST_B),
		.async_in(EVT_TRIG),
		.level_out(),
		.rise_out(evt_rise)
	);

	// Triggers arriving while a run is busy are dropped, not queued
	assign trigger = sw_start || (ctrl_ff[CTRL_EVT_BIT] && evt_rise) || free_run;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			free_prev_ff <= 1'b0;
		end else begin
			free_prev_ff <= free_run;
		end
	end

	// Abort leaves partial sums behind; software flushes them with a disable
	assign free_abort = free_prev_ff && !free_run && (state_ff != ST_IDLE); // RQ6 RQ7
	assign sample_in = (state_ff == ST_WAIT) && CONV_DONE;
	assign last_sample = (samp_cnt_ff == n_last);
	assign more_chan = (scan_idx_ff != scan_last);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_ff <= ST_IDLE;
		end else if (!en) begin
			state_ff <= ST_IDLE;
		end else if (free_abort) begin
			state_ff <= ST_IDLE; // RQ6
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (trigger) begin
						state_ff <= ST_REQ; // RQ2 RQ5
					end
				end
				ST_REQ: begin
					state_ff <= ST_WAIT;
				end
				ST_WAIT: begin
					if (sample_in) begin
						state_ff <= last_sample ? ST_AVG : ST_REQ; // RQ2 RQ5
					end
				end
				ST_AVG: begin
					if (more_chan || free_run) begin
						state_ff <= ST_REQ;
					end else begin
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			samp_cnt_ff <= '0;
		end else if (!en) begin
			samp_cnt_ff <= '0; // RQ9
		end else if (sample_in && !free_abort) begin
			samp_cnt_ff <= last_sample ? '0 : CNT_W'(samp_cnt_ff + CNT_W'(1));
		end
	end

	// Scan offset moves only once the channel's average is out
	always_comb begin
		nxt_scan_idx = scan_idx_ff;
		if (!en || (state_ff == ST_IDLE)) begin
			nxt_scan_idx = '0;
		end else if ((state_ff == ST_AVG) && !free_abort) begin
			nxt_scan_idx = more_chan ? CHAN_W'(scan_idx_ff + CHAN_W'(1)) : '0; // RQ1
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			scan_idx_ff <= '0;
		end else begin
			scan_idx_ff <= nxt_scan_idx;
		end
	end

	// Channel follows the next index, so the first start of a new
	// channel already carries that channel and not the previous one
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			chan_ff <= '0;
		end else begin
			chan_ff <= CHAN_W'(chan_base + nxt_scan_idx); // RQ1
		end
	end

	assign CONV_START = (state_ff == ST_REQ) && en && !free_abort;
	assign CONV_CHAN = chan_ff;

	assign acc_clr = !en || (state_ff == ST_AVG); // RQ9
	aavs_accum u_accum (
		.clk(CLK),
		.rst_b(RST_B),
		.clr(acc_clr),
		.add(sample_in && en && !free_abort),
		.signed_mode(ctrl_ff[CTRL_SIGNED_BIT]),
		.shift(shift),
		.sample(CONV_DATA),
		.avg(avg)
	);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			result_ff <= RES_RST;
		end else if (en && (state_ff == ST_AVG) && !free_abort) begin
			result_ff <= correct(avg, offs_ff, ctrl_ff[CTRL_OFFCOR_BIT],
				ctrl_ff[CTRL_SIGNED_BIT]); // RQ8
		end
	end

	// Completion wins over a clear in the same cycle
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			done_ff <= 1'b0;
		end else if (en && (state_ff == ST_AVG) && !free_abort) begin
			done_ff <= 1'b1; // RQ3
		end else if (done_clr) begin
			done_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			AVG_DONE_IRQ <= 1'b0;
		end else begin
			AVG_DONE_IRQ <= done_ff && ctrl_ff[CTRL_IRQEN_BIT]; // RQ3
		end
	end

endmodule

/* verif/aavs_core_model.sv */
// Purpose: Behavioural converter core.
// Assumes: One start at a time; answer after 3 or 10 cycles.
// Notes: Samples alternate lvl+chan and lvl+chan+2.
`timescale 1ns/1ps
module aavs_core_model
	import aavs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic restart,
	input wire logic slow,
	input wire logic [SAMPLE_W-1:0] lvl,
	input wire logic conv_start,
	input wire logic [CHAN_W-1:0] conv_chan,
	output logic conv_done,
	output logic [SAMPLE_W-1:0] conv_data
);
	logic [3:0] cnt_ff;
	logic alt_ff;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= 4'h0;
			alt_ff <= 1'b0;
			conv_done <= 1'b0;
			conv_data <= 12'h000;
		end else begin
			conv_done <= 1'b0;
			// Data outside done toggles, so a stale sample is never reused
			conv_data <= ~conv_data;
			if (restart)
				alt_ff <= 1'b0;
			if (conv_start)
				cnt_ff <= slow ? 4'h9 : 4'h2;
			else if (cnt_ff == 4'h1) begin
				conv_done <= 1'b1;
				conv_data <= lvl + {8'h00, conv_chan} + (alt_ff ? 12'h002 : 12'h000);
				alt_ff <= ~alt_ff;
				cnt_ff <= 4'h0;
			end else if (cnt_ff != 4'h0)
				cnt_ff <= cnt_ff - 4'h1;
		end
	end
endmodule

/* verif/aavs_properties.sv */
// Purpose: Port checks of the averaging sequencer.
// Assumes: Bound to aavs_top; one core conversion in flight.
// Notes: pend_ff marks a start not yet answered.
`timescale 1ns/1ps
module aavs_properties
	import aavs_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic CONV_START,
	input wire logic [CHAN_W-1:0] CONV_CHAN,
	input wire logic CONV_DONE,
	input wire logic AVG_DONE_IRQ
);
	logic pend_ff;
	logic rd_req;
	logic wr_req;
	assign rd_req = HSEL && HREADY && HTRANS == HTRANS_NONSEQ && !HWRITE;
	assign wr_req = HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HWRITE;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			pend_ff <= 1'b0;
		else if (CONV_START)
			pend_ff <= 1'b1;
		else if (CONV_DONE)
			pend_ff <= 1'b0;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	sequence s_next;
		CONV_DONE ##1 CONV_START;
	endsequence
	chk_start_pulse: assert property (CONV_START |=> !CONV_START)
		else $error("start wider than one cycle");
	chk_start_order: assert property (CONV_START |-> !pend_ff && !CONV_DONE)
		else $error("start before core answered");
	chk_chan_keep: assert property (s_next |-> $stable(CONV_CHAN))
		else $error("channel moved inside a run");
	chk_chan_wait: assert property (pend_ff |-> $stable(CONV_CHAN))
		else $error("channel moved during conversion");
	chk_irq_after_avg: assert property ($rose(AVG_DONE_IRQ) |->
		$past(CONV_DONE, 3) && !$past(CONV_START, 2))
		else $error("irq without finished average");
	chk_irq_drop: assert property ($fell(AVG_DONE_IRQ) |->
		$past(wr_req, 3) || $past(wr_req, 2))
		else $error("irq dropped without a write");
	chk_rdata_hold: assert property (!$past(rd_req) |-> $stable(HRDATA))
		else $error("read data moved");
	chk_bus_okay: assert property (HREADYOUT && HRESP == HRESP_OKAY)
		else $error("bus not ready or not okay");
endmodule

/* verif/tb_top.sv */
// Purpose: Self-checking bench of the averaging sequencer.
// Assumes: AHB-Lite master, one core model.
// Notes: Even N keeps the alternating samples averaging exactly.
`timescale 1ns/1ps
module tb_top
	import aavs_pkg::*;
;
	localparam logic [31:0] EN = 32'h1 << CTRL_EN_BIT;
	localparam logic [31:0] ST = 32'h1 << CTRL_START_BIT;
	localparam logic [31:0] FR = 32'h1 << CTRL_FREE_BIT;
	localparam logic [31:0] EV = 32'h1 << CTRL_EVT_BIT;
	localparam logic [31:0] SC = 32'h1 << CTRL_SCAN_BIT;
	localparam logic [31:0] OC = 32'h1 << CTRL_OFFCOR_BIT;
	localparam logic [31:0] SG = 32'h1 << CTRL_SIGNED_BIT;
	localparam logic [31:0] IE = 32'h1 << CTRL_IRQEN_BIT;
	logic CLK = 1'b0;
	logic RST_B = 1'b0;
	logic HSEL = 1'b0;
	logic HWRITE = 1'b0;
	logic EVT_TRIG = 1'b0;
	logic restart = 1'b0;
	logic slow = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [31:0] HWDATA = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic [2:0] HSIZE = 3'h2;
	logic [11:0] lvl = 12'h000;
	logic [31:0] HRDATA;
	logic [31:0] v;
	logic HREADYOUT, HRESP, CONV_START, CONV_DONE, AVG_DONE_IRQ;
	logic [3:0] CONV_CHAN;
	logic [11:0] CONV_DATA;
	logic [3:0] chans [$];
	int n_fail = 0;
	int n_tests = 0;
	int n_start = 0;
	int seen;
	always #2 CLK = ~CLK;
	always @(posedge CLK) begin
		if (CONV_START === 1'b1) begin
			n_start++;
			chans.push_back(CONV_CHAN);
		end
	end
	aavs_top dut (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EVT_TRIG(EVT_TRIG),
		.CONV_START(CONV_START), .CONV_CHAN(CONV_CHAN), .CONV_DONE(CONV_DONE),
		.CONV_DATA(CONV_DATA), .AVG_DONE_IRQ(AVG_DONE_IRQ));
	aavs_core_model core (.clk(CLK), .rst_b(RST_B), .restart(restart), .slow(slow),
		.lvl(lvl), .conv_start(CONV_START), .conv_chan(CONV_CHAN), .conv_done(CONV_DONE),
		.conv_data(CONV_DATA));
	task tally_and_finish;
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= HTRANS_NONSEQ;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		v = HRDATA;
	endtask
	// Waits for busy low with done high: scans set done per channel
	task run(input logic [31:0] ctl, input int n, input logic [31:0] exp);
		n_start = 0;
		chans.delete();
		restart <= 1'b1;
		@(posedge CLK);
		restart <= 1'b0;
		xfer(OFF_CTRL, 1'b1, ctl);
		if (ctl[CTRL_EVT_BIT]) begin
			EVT_TRIG <= 1'b1;
			repeat (6) @(posedge CLK);
			EVT_TRIG <= 1'b0;
		end
		v = 32'h0;
		for (int i = 0; i < 300 && v[1:0] !== 2'b10; i++)
			xfer(OFF_STAT, 1'b0, 32'h0);
		chk(n_start, n);
		xfer(OFF_RES, 1'b0, 32'h0);
		chk(v, exp);
		chk({31'h0, AVG_DONE_IRQ}, {31'h0, ctl[CTRL_IRQEN_BIT]});
		xfer(OFF_STAT, 1'b1, 32'h1 << STAT_DONE_BIT);
		repeat (2) @(posedge CLK);
		chk({31'h0, AVG_DONE_IRQ}, 32'h0);
	endtask
	initial begin
		repeat (2) @(posedge CLK);
		RST_B <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			xfer(8'(4 * i), 1'b0, 32'h0);
			chk(v, 32'h0);
		end
		xfer(8'h40, 1'b1, 32'hffffffff);
		xfer(8'h40, 1'b0, 32'h0);
		chk(v, 32'h0);
		// Start is only honoured once enable already stands
		xfer(OFF_CTRL, 1'b1, EN);
		lvl <= 12'h100;
		xfer(OFF_CFG, 1'b1, 32'h0301);
		run(EN | IE | ST, 2, 32'h104);
		xfer(OFF_CFG, 1'b1, 32'h0102);
		run(EN | IE | EV, 4, 32'h102);
		xfer(OFF_CFG, 1'b1, 32'h2201);
		run(EN | SC | ST, 6, 32'h105);
		for (int i = 0; i < 6; i++)
			chk(chans[i], 2 + i / 2);
		lvl <= 12'hfff;
		xfer(OFF_CFG, 1'b1, 32'h0001);
		run(EN | ST, 2, 32'h800);
		lvl <= 12'h100;
		xfer(OFF_CFG, 1'b1, 32'h0000);
		xfer(OFF_OFFS, 1'b1, 32'h200);
		run(EN | OC | ST, 1, 32'h0);
		xfer(OFF_OFFS, 1'b1, 32'h050);
		run(EN | OC | ST, 1, 32'h0b0);
		// Signed mode wraps below zero instead of saturating
		lvl <= 12'hfff;
		xfer(OFF_CFG, 1'b1, 32'h0001);
		run(EN | SG | OC | ST, 2, 32'hfb0);
		slow <= 1'b1;
		xfer(OFF_CFG, 1'b1, 32'h0003);
		xfer(OFF_CTRL, 1'b1, EN | FR);
		repeat (30) @(posedge CLK);
		xfer(OFF_CTRL, 1'b1, EN);
		repeat (3) @(posedge CLK);
		seen = n_start;
		repeat (40) @(posedge CLK);
		chk(n_start, seen);
		xfer(OFF_STAT, 1'b0, 32'h0);
		chk(v[STAT_BUSY_BIT], 1'b0);
		// Flush the stale partial sum before the next run
		xfer(OFF_CTRL, 1'b1, 32'h0);
		xfer(OFF_CTRL, 1'b1, EN);
		xfer(OFF_STAT, 1'b0, 32'h0);
		chk(v[23:16], 8'h00);
		slow <= 1'b0;
		lvl <= 12'h040;
		xfer(OFF_CFG, 1'b1, 32'h0001);
		run(EN | ST, 2, 32'h041);
		tally_and_finish;
	end
	initial begin
		#100000;
		n_fail++;
		tally_and_finish;
	end
endmodule
bind aavs_top aavs_properties chk_i (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .CONV_START(CONV_START),
	.CONV_CHAN(CONV_CHAN), .CONV_DONE(CONV_DONE), .AVG_DONE_IRQ(AVG_DONE_IRQ));
